/* File: hdl/rstr_pkg.sv */
package rstr_pkg;
   // =======================================
   // Widths
   localparam int USER_W = 256;
   localparam int ENG_W = 128;
   localparam int ADDR_W = 48;
   localparam int CNT_W = 16;
   localparam int ERR_W = 32;
   localparam int SUB_W = 512;
   // =======================================
   // Sizes in bytes, user FIFO depth in 256-bit words
   localparam int SECT_BYTES = 512;
   localparam int FIFO_BYTES = 16384;
   localparam int IDEN_BYTES = 8192;
   localparam int CTM_BYTES = 512;
   localparam int EGRESS_FREE_BYTES = 1024;
   localparam int USER_FIFO_DEPTH = 512;
   // =======================================
   // Derived counts
   localparam int BEATS = SECT_BYTES / (USER_W / 8);
   localparam logic [3:0] LAST_BEAT = 4'hf;
   localparam int INGRESS_MIN_ENTRIES = SECT_BYTES / (ENG_W / 8);
   localparam int EGRESS_FREE_ENTRIES = EGRESS_FREE_BYTES / (ENG_W / 8);
   localparam int RX_CNT_LSB = 5;
   localparam logic [10:0] RX_NEAR_FULL = 11'h7ff;
   localparam logic [ADDR_W-1:0] CAPACITY_RESET = 48'h0;
   // =======================================
   // Commands and states
   typedef enum logic [2:0] {
      CMD_IDENTIFY = 3'h0,
      CMD_SHUTDOWN = 3'h1,
      CMD_WRITE = 3'h2,
      CMD_READ = 3'h3,
      CMD_SMART = 3'h4,
      CMD_FLUSH = 3'h6
   } rstr_cmd_t;
   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_DRAIN} rstr_state_t;
   typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_WAIT} rstr_hstate_t;
endpackage

/* File: hdl/rstr_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface rstr_if;
   logic [2:0] host_command_code;
   logic [47:0] host_start_sector;
   logic [47:0] host_sector_count;
   logic host_command_request;
   logic [511:0] custom_submission_words;
   logic array_busy_flag;
   logic [47:0] array_capacity_sectors;
   logic sector_size_indicator;
   logic array_error_flag;
   logic [63:0] channel_error_vector;
   logic [15:0] rx_user_fifo_write_count;
   logic rx_user_fifo_push;
   logic [255:0] rx_user_fifo_push_word;
   logic [15:0] tx_user_fifo_read_count;
   logic tx_user_fifo_empty_flag;
   logic tx_user_fifo_pop;
   logic [255:0] tx_user_fifo_pop_word;
   modport array (
      input host_command_code, host_start_sector, host_sector_count,
      input host_command_request, custom_submission_words,
      input rx_user_fifo_write_count, tx_user_fifo_read_count,
      input tx_user_fifo_empty_flag, tx_user_fifo_pop_word,
      output array_busy_flag, array_capacity_sectors, sector_size_indicator,
      output array_error_flag, channel_error_vector,
      output rx_user_fifo_push, rx_user_fifo_push_word, tx_user_fifo_pop
   );
   modport host (
      output host_command_code, host_start_sector, host_sector_count,
      output host_command_request, custom_submission_words,
      output rx_user_fifo_write_count, tx_user_fifo_read_count,
      output tx_user_fifo_empty_flag, tx_user_fifo_pop_word,
      input array_busy_flag, array_capacity_sectors, sector_size_indicator,
      input array_error_flag, channel_error_vector,
      input rx_user_fifo_push, rx_user_fifo_push_word, tx_user_fifo_pop
   );
endinterface
`default_nettype wire

/* File: hdl/rstr_user.sv */
`timescale 1ns/100ps
`default_nettype none
module rstr_user #(
   parameter int DEPTH = rstr_pkg::USER_FIFO_DEPTH
) (
   // System
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sync_reset_n,
   // Link
   rstr_if.host lnk,
   // Command
   input wire logic cmd_start,
   input wire logic [2:0] cmd_code,
   input wire logic [rstr_pkg::ADDR_W-1:0] cmd_sector,
   input wire logic [rstr_pkg::ADDR_W-1:0] cmd_count,
   input wire logic [rstr_pkg::SUB_W-1:0] cmd_sub_words,
   output logic cmd_ready,
   output logic cmd_done,
   // Write data source
   input wire logic src_push,
   input wire logic [rstr_pkg::USER_W-1:0] src_word,
   output logic src_room,
   // Read data sink
   input wire logic snk_pop,
   output logic snk_valid,
   output logic [rstr_pkg::USER_W-1:0] snk_word
);
   import rstr_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] SAT = '1;

   // ======================================
   // Command handshake
   rstr_hstate_t hs_r, hs_nxt;
   logic [2:0] code_r, code_nxt;
   logic [47:0] sec_r, sec_nxt, cnt_r, cnt_nxt;
   logic [511:0] sub_r, sub_nxt;
   logic done_r, done_nxt;

   always_comb
   begin
      hs_nxt = hs_r;
      code_nxt = code_r;
      sec_nxt = sec_r;
      cnt_nxt = cnt_r;
      sub_nxt = sub_r;
      done_nxt = 1'b0;
      case (hs_r)
         HS_IDLE:
            if (cmd_start && !lnk.array_busy_flag)
            begin
               hs_nxt = HS_REQ;
               code_nxt = cmd_code;
               sec_nxt = cmd_sector;
               cnt_nxt = cmd_count;
               sub_nxt = cmd_sub_words;
            end
         HS_REQ:
            if (lnk.array_busy_flag)
               hs_nxt = HS_WAIT;
         HS_WAIT:
            if (!lnk.array_busy_flag)
            begin
               hs_nxt = HS_IDLE;
               done_nxt = 1'b1;
            end
         default: hs_nxt = HS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!sync_reset_n)
      begin
         hs_r <= HS_IDLE;
         code_r <= 3'h0;
         sec_r <= 48'h0;
         cnt_r <= 48'h0;
         sub_r <= '0;
         done_r <= 1'b0;
      end
      else if (clk_en)
      begin
         hs_r <= hs_nxt;
         code_r <= code_nxt;
         sec_r <= sec_nxt;
         cnt_r <= cnt_nxt;
         sub_r <= sub_nxt;
         done_r <= done_nxt;
      end
   end

   // Parameters stay put from request until the next start
   assign lnk.host_command_request = (hs_r == HS_REQ);
   assign lnk.host_command_code = code_r;
   assign lnk.host_start_sector = sec_r;
   assign lnk.host_sector_count = cnt_r;
   assign lnk.custom_submission_words = sub_r;
   assign cmd_ready = (hs_r == HS_IDLE);
   assign cmd_done = done_r;

   // ======================================
   // Transmit and receive FIFOs
   logic [255:0] tmem [DEPTH];
   logic [255:0] rmem [DEPTH];
   logic [AW-1:0] twp_r, trp_r, rwp_r, rrp_r;
   logic [AW:0] tlvl_r, rlvl_r;
   logic [255:0] tword_r, rword_r;
   logic rvalid_r;
   logic tpush, tpop, rpush, rpop;

   assign tpush = src_push && (tlvl_r != FULL);
   assign tpop = lnk.tx_user_fifo_pop && (tlvl_r != '0);
   assign rpush = lnk.rx_user_fifo_push && (rlvl_r != FULL);
   assign rpop = snk_pop && (rlvl_r != '0);

   always_ff @(posedge clk)
   begin
      if (!sync_reset_n)
      begin
         twp_r <= '0;
         trp_r <= '0;
         rwp_r <= '0;
         rrp_r <= '0;
         tlvl_r <= '0;
         rlvl_r <= '0;
         tword_r <= '0;
         rword_r <= '0;
         rvalid_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (tpush)
         begin
            tmem[twp_r] <= src_word;
            twp_r <= twp_r + 1'b1;
         end
         if (tpop)
         begin
            tword_r <= tmem[trp_r];
            trp_r <= trp_r + 1'b1;
         end
         tlvl_r <= tlvl_r + (AW+1)'(tpush) - (AW+1)'(tpop);
         if (rpush)
         begin
            rmem[rwp_r] <= lnk.rx_user_fifo_push_word;
            rwp_r <= rwp_r + 1'b1;
         end
         rvalid_r <= rpop;
         if (rpop)
         begin
            rword_r <= rmem[rrp_r];
            rrp_r <= rrp_r + 1'b1;
         end
         rlvl_r <= rlvl_r + (AW+1)'(rpush) - (AW+1)'(rpop);
      end
   end

   // Transmit level zero-padded, receive level saturated and padded with ones to 16 bits
   assign lnk.tx_user_fifo_read_count = {{(CNT_W-AW-1){1'b0}}, tlvl_r};
   assign lnk.rx_user_fifo_write_count =
      {{(CNT_W-AW){1'b1}}, (rlvl_r[AW] ? SAT : rlvl_r[AW-1:0])};
   assign lnk.tx_user_fifo_empty_flag = (tlvl_r == '0);
   assign lnk.tx_user_fifo_pop_word = tword_r;
   assign src_room = (tlvl_r != FULL);
   assign snk_valid = rvalid_r;
   assign snk_word = rword_r;
endmodule
`default_nettype wire

/* File: hdl/rstr_array.sv */
// How it works
// - SMART/Flush use custom words, others standard parameters
// - User FIFO 256 bits, buffers 128 bits
// - Dword mask AND strobe makes byte enables
// - Identify buffer 8 KB, 128 in, 32 out
// - Custom buffer true dual port, 512 bytes
// - Per channel egress and ingress width-converting FIFOs
// - Split address and length for read/write, request engines with nonzero length; other commands request both
// - Sector counter bit 0 picks channel
// - Synchronous active-low reset
// - Three-bit command code set
// - Start address in sectors, aligned preferred
// - Length from 1 to capacity minus start
// - Request only when idle, parameters held
// - Capacity is sum, zero until Identify
// - Sector size flag zero until Identify
// - Sticky error flag, reset clears
// - Channel error vectors copied from engines
// - User counters padded to 16 bits
// - Transmit FIFO data one cycle after pop
// - Write burst waits for data and space
// - Sixteen pops, egress push two clocks later
// - Read burst waits, sixteen pops and pushes
`timescale 1ns/100ps
`default_nettype none
module rstr_array #(
   parameter int FIFO_BYTES = rstr_pkg::FIFO_BYTES,
   parameter int IDEN_BYTES = rstr_pkg::IDEN_BYTES,
   parameter int CTM_BYTES = rstr_pkg::CTM_BYTES,
   parameter int ENTRIES = FIFO_BYTES / (rstr_pkg::ENG_W / 8),
   parameter int LW = $clog2(ENTRIES) + 1,
   parameter int IW = $clog2(IDEN_BYTES / (rstr_pkg::ENG_W / 8)),
   parameter int CW = $clog2(CTM_BYTES / (rstr_pkg::ENG_W / 8))
) (
   // System
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sync_reset_n,
   // User link
   rstr_if.array lnk,
   // Engine commands and status
   output logic [1:0] eng_cmd_req,
   output logic [2:0] eng_cmd_code,
   output logic [1:0][rstr_pkg::ADDR_W-1:0] eng_addr,
   output logic [1:0][rstr_pkg::ADDR_W-1:0] eng_len,
   output logic [rstr_pkg::SUB_W-1:0] eng_sub_words,
   input wire logic [1:0] eng_busy,
   input wire logic [1:0][rstr_pkg::ERR_W-1:0] eng_err_type,
   input wire logic [1:0][rstr_pkg::ADDR_W-1:0] eng_capacity,
   input wire logic [1:0] eng_lba_mode,
   // Engine data
   input wire logic [1:0] eng_tx_pop,
   output logic [1:0][rstr_pkg::ENG_W-1:0] eng_tx_word,
   output logic [1:0][LW-1:0] eng_tx_level,
   input wire logic [1:0] eng_rx_push,
   input wire logic [1:0][rstr_pkg::ENG_W-1:0] eng_rx_word,
   output logic [1:0][LW-1:0] eng_rx_level,
   // Identify buffer
   input wire logic iden_strobe,
   input wire logic [3:0] iden_mask,
   input wire logic [IW-1:0] iden_index,
   input wire logic [rstr_pkg::ENG_W-1:0] iden_word,
   input wire logic [IW+1:0] iden_rd_addr,
   output logic [31:0] iden_rd_word,
   // Custom response buffer, two ports
   input wire logic [1:0] ctm_strobe,
   input wire logic [1:0][3:0] ctm_mask,
   input wire logic [1:0][CW-1:0] ctm_index,
   input wire logic [1:0][rstr_pkg::ENG_W-1:0] ctm_word,
   output logic [1:0][rstr_pkg::ENG_W-1:0] ctm_rd_word
);
   import rstr_pkg::*;
   localparam logic [LW-1:0] FULL = LW'(ENTRIES);

   function automatic logic [15:0] byte_en(input logic [3:0] mask, input logic strobe);
      logic [15:0] be;
      be = '0;
      for (int d = 0; d < 4; d++)
         be[4*d +: 4] = {4{mask[d] & strobe}};
      return be;
   endfunction

   // ======================================
   // Command control
   rstr_state_t state_r, state_nxt;
   logic busy_r, busy_nxt, burst_r, burst_nxt, p1_r, p1_nxt, p2_r, p2_nxt;
   logic p1ch_r, p1ch_nxt, p2ch_r, p2ch_nxt, mode_r, mode_nxt, err_r, err_nxt;
   logic [2:0] cmd_r, cmd_nxt;
   logic [3:0] beat_r, beat_nxt;
   logic [47:0] cur_r, cur_nxt, rem_r, rem_nxt, cap_r, cap_nxt;
   logic [1:0] ereq_r, ereq_nxt;
   logic [1:0][47:0] eaddr_r, eaddr_nxt, elen_r, elen_nxt;
   logic [511:0] sub_r, sub_nxt;
   logic [63:0] errv_r;
   logic [48:0] a49, e49, s0, s1, n0, n1;
   logic data_cmd, is_wr, go_ok;
   logic [1:0][LW-1:0] elvl, ilvl;
   logic [1:0][255:0] ird;

   assign is_wr = (cmd_r == CMD_WRITE);
   always_comb
   begin
      a49 = {1'b0, lnk.host_start_sector};
      e49 = a49 + {1'b0, lnk.host_sector_count};
      s0 = (a49 + 49'h1) >> 1;
      n0 = ((e49 + 49'h1) >> 1) - s0;
      s1 = a49 >> 1;
      n1 = (e49 >> 1) - s1;
      data_cmd = (lnk.host_command_code == CMD_WRITE) || (lnk.host_command_code == CMD_READ);
      if (is_wr)
         go_ok = (lnk.tx_user_fifo_read_count >= CNT_W'(BEATS))
            && ((FULL - elvl[cur_r[0]]) >= LW'(EGRESS_FREE_ENTRIES));
      else
         go_ok = (ilvl[cur_r[0]] >= LW'(INGRESS_MIN_ENTRIES))
            && (lnk.rx_user_fifo_write_count[CNT_W-1:RX_CNT_LSB] != RX_NEAR_FULL);
   end

   always_comb
   begin
      state_nxt = state_r;
      busy_nxt = busy_r;
      cmd_nxt = cmd_r;
      cur_nxt = cur_r;
      rem_nxt = rem_r;
      burst_nxt = burst_r;
      beat_nxt = beat_r;
      cap_nxt = cap_r;
      mode_nxt = mode_r;
      eaddr_nxt = eaddr_r;
      elen_nxt = elen_r;
      sub_nxt = sub_r;
      ereq_nxt = ereq_r & ~eng_busy;
      p1_nxt = burst_r;
      p1ch_nxt = cur_r[0];
      p2_nxt = p1_r;
      p2ch_nxt = p1ch_r;
      err_nxt = err_r | (|eng_err_type);
      case (state_r)
         ST_IDLE:
            if (lnk.host_command_request)
            begin
               state_nxt = ST_MOVE;
               busy_nxt = 1'b1;
               cmd_nxt = lnk.host_command_code;
               cur_nxt = lnk.host_start_sector;
               rem_nxt = data_cmd ? lnk.host_sector_count : 48'h0;
               sub_nxt = lnk.custom_submission_words;
               if (data_cmd)
               begin
                  eaddr_nxt[0] = s0[47:0];
                  eaddr_nxt[1] = s1[47:0];
                  elen_nxt[0] = n0[47:0];
                  elen_nxt[1] = n1[47:0];
                  ereq_nxt = {n1 != 49'h0, n0 != 49'h0};
               end
               else
               begin
                  eaddr_nxt = '0;
                  elen_nxt = '0;
                  ereq_nxt = 2'b11;
               end
            end
         ST_MOVE:
            if (burst_r)
            begin
               beat_nxt = beat_r + 4'h1;
               if (beat_r == LAST_BEAT)
               begin
                  burst_nxt = 1'b0;
                  cur_nxt = cur_r + 48'h1;
                  rem_nxt = rem_r - 48'h1;
               end
            end
            else if (!p1_r && !p2_r)
            begin
               if (rem_r == 48'h0)
                  state_nxt = ST_DRAIN;
               else if (go_ok)
               begin
                  burst_nxt = 1'b1;
                  beat_nxt = 4'h0;
               end
            end
         ST_DRAIN:
            if (ereq_r == 2'b00 && eng_busy == 2'b00)
            begin
               state_nxt = ST_IDLE;
               busy_nxt = 1'b0;
               if (cmd_r == CMD_IDENTIFY)
               begin
                  cap_nxt = 48'(eng_capacity[0] + eng_capacity[1]);
                  mode_nxt = |eng_lba_mode;
               end
            end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!sync_reset_n)
      begin
         state_r <= ST_IDLE;
         busy_r <= 1'b0;
         cmd_r <= 3'h0;
         cur_r <= 48'h0;
         rem_r <= 48'h0;
         burst_r <= 1'b0;
         beat_r <= 4'h0;
         cap_r <= CAPACITY_RESET;
         mode_r <= 1'b0;
         eaddr_r <= '0;
         elen_r <= '0;
         sub_r <= '0;
         ereq_r <= 2'b00;
         p1_r <= 1'b0;
         p1ch_r <= 1'b0;
         p2_r <= 1'b0;
         p2ch_r <= 1'b0;
         err_r <= 1'b0;
         errv_r <= '0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         cmd_r <= cmd_nxt;
         cur_r <= cur_nxt;
         rem_r <= rem_nxt;
         burst_r <= burst_nxt;
         beat_r <= beat_nxt;
         cap_r <= cap_nxt;
         mode_r <= mode_nxt;
         eaddr_r <= eaddr_nxt;
         elen_r <= elen_nxt;
         sub_r <= sub_nxt;
         ereq_r <= ereq_nxt;
         p1_r <= p1_nxt;
         p1ch_r <= p1ch_nxt;
         p2_r <= p2_nxt;
         p2ch_r <= p2ch_nxt;
         err_r <= err_nxt;
         errv_r <= eng_err_type;
      end
   end

   assign lnk.array_busy_flag = busy_r;
   assign lnk.array_capacity_sectors = cap_r;
   assign lnk.sector_size_indicator = mode_r;
   assign lnk.array_error_flag = err_r;
   assign lnk.channel_error_vector = errv_r;
   assign eng_cmd_req = ereq_r;
   assign eng_cmd_code = cmd_r;
   assign eng_addr = eaddr_r;
   assign eng_len = elen_r;
   assign eng_sub_words = sub_r;

   // ======================================
   // Data switch
   logic wpop_r, upush_r;
   logic [255:0] wdat_r, uword_r;

   always_ff @(posedge clk)
   begin
      if (!sync_reset_n)
      begin
         wpop_r <= 1'b0;
         upush_r <= 1'b0;
         wdat_r <= '0;
         uword_r <= '0;
      end
      else if (clk_en)
      begin
         wpop_r <= burst_nxt && is_wr;
         wdat_r <= lnk.tx_user_fifo_pop_word;
         upush_r <= p1_r && !is_wr;
         uword_r <= ird[p1ch_r];
      end
   end

   assign lnk.tx_user_fifo_pop = wpop_r;
   assign lnk.rx_user_fifo_push = upush_r;
   assign lnk.rx_user_fifo_push_word = uword_r;

   // ======================================
   // Channel FIFOs, 256 to 128 and back
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      logic [127:0] emem [ENTRIES];
      logic [127:0] imem [ENTRIES];
      logic [LW-2:0] ewp_r, erp_r, iwp_r, irp_r;
      logic [LW-1:0] elvl_r, ilvl_r;
      logic [127:0] eword_r;
      logic [255:0] ird_r;
      logic epush, epop, ipush, ipop;

      assign epush = p2_r && is_wr && (p2ch_r == 1'(c));
      assign epop = eng_tx_pop[c] && (elvl_r != '0);
      assign ipush = eng_rx_push[c] && (ilvl_r != FULL);
      assign ipop = burst_r && !is_wr && (cur_r[0] == 1'(c));

      always_ff @(posedge clk)
      begin
         if (!sync_reset_n)
         begin
            ewp_r <= '0;
            erp_r <= '0;
            iwp_r <= '0;
            irp_r <= '0;
            elvl_r <= '0;
            ilvl_r <= '0;
            eword_r <= '0;
            ird_r <= '0;
         end
         else if (clk_en)
         begin
            if (epush)
            begin
               emem[ewp_r] <= wdat_r[127:0];
               emem[ewp_r + 1'b1] <= wdat_r[255:128];
               ewp_r <= ewp_r + 2'h2;
            end
            if (epop)
            begin
               eword_r <= emem[erp_r];
               erp_r <= erp_r + 1'b1;
            end
            elvl_r <= elvl_r + (epush ? LW'(2) : LW'(0)) - LW'(epop);
            if (ipush)
            begin
               imem[iwp_r] <= eng_rx_word[c];
               iwp_r <= iwp_r + 1'b1;
            end
            if (ipop)
            begin
               ird_r <= {imem[irp_r + 1'b1], imem[irp_r]};
               irp_r <= irp_r + 2'h2;
            end
            ilvl_r <= ilvl_r + LW'(ipush) - (ipop ? LW'(2) : LW'(0));
         end
      end

      assign elvl[c] = elvl_r;
      assign ilvl[c] = ilvl_r;
      assign ird[c] = ird_r;
      assign eng_tx_word[c] = eword_r;
      assign eng_tx_level[c] = elvl_r;
      assign eng_rx_level[c] = ilvl_r;
   end

   // ======================================
   // Identify and custom response buffers
   logic [127:0] iden_mem [2**IW];
   logic [127:0] ctm_mem [2**CW];
   logic [31:0] iden_rd_r;
   logic [1:0][127:0] ctm_rd_r;
   logic [15:0] iden_be;
   logic [1:0][15:0] ctm_be;

   assign iden_be = byte_en(iden_mask, iden_strobe);
   assign ctm_be[0] = byte_en(ctm_mask[0], ctm_strobe[0]);
   assign ctm_be[1] = byte_en(ctm_mask[1], ctm_strobe[1]);

   always_ff @(posedge clk)
   begin
      if (!sync_reset_n)
      begin
         iden_rd_r <= 32'h0;
         ctm_rd_r <= '0;
      end
      else if (clk_en)
      begin
         for (int b = 0; b < 16; b++)
         begin
            if (iden_be[b])
               iden_mem[iden_index][8*b +: 8] <= iden_word[8*b +: 8];
            for (int p = 0; p < 2; p++)
               if (ctm_be[p][b])
                  ctm_mem[ctm_index[p]][8*b +: 8] <= ctm_word[p][8*b +: 8];
         end
         iden_rd_r <= iden_mem[iden_rd_addr[IW+1:2]][32*iden_rd_addr[1:0] +: 32];
         ctm_rd_r[0] <= ctm_mem[ctm_index[0]];
         ctm_rd_r[1] <= ctm_mem[ctm_index[1]];
      end
   end

   assign iden_rd_word = iden_rd_r;
   assign ctm_rd_word = ctm_rd_r;
endmodule
`default_nettype wire

/* File: tb/rstr_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rstr_assertions (
   // System
   input wire logic clk,
   input wire logic sync_reset_n,
   // Link
   input wire logic host_command_request,
   input wire logic array_busy_flag,
   input wire logic [47:0] array_capacity_sectors,
   input wire logic array_error_flag,
   input wire logic [63:0] channel_error_vector,
   input wire logic [15:0] rx_user_fifo_write_count,
   input wire logic rx_user_fifo_push,
   input wire logic [15:0] tx_user_fifo_read_count,
   input wire logic tx_user_fifo_pop
);
   // ====
   // Burst length counters
   logic [4:0] pop_r, pop_nxt, psh_r, psh_nxt;
   logic [10:0] rx_hi;
   assign rx_hi = rx_user_fifo_write_count[15:5];
   always_comb
   begin
      pop_nxt = tx_user_fifo_pop ? pop_r + 5'h1 : 5'h0;
      psh_nxt = rx_user_fifo_push ? psh_r + 5'h1 : 5'h0;
   end
   always_ff @(posedge clk)
   begin
      pop_r <= sync_reset_n ? pop_nxt : 5'h0;
      psh_r <= sync_reset_n ? psh_nxt : 5'h0;
   end
   // ====
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!sync_reset_n);
   sequence s_take;
      host_command_request && !array_busy_flag;
   endsequence
   a_busy_after_take: assert property (s_take |=> array_busy_flag)
      else $error("busy late");
   a_pop_sixteen: assert property ($fell(tx_user_fifo_pop) |-> pop_r == 5'h10)
      else $error("pop burst");
   a_pop_max: assert property (tx_user_fifo_pop |-> pop_r < 5'h10)
      else $error("pop long");
   a_push_sixteen: assert property ($fell(rx_user_fifo_push) |-> psh_r == 5'h10)
      else $error("push burst");
   a_tx_room: assert property ($rose(tx_user_fifo_pop) |-> $past(tx_user_fifo_read_count) >= 16'h10)
      else $error("tx short");
   a_rx_room: assert property ($rose(rx_user_fifo_push) |-> $past(rx_hi, 3) != 11'h7ff)
      else $error("rx full");
   a_err_sticky: assert property (array_error_flag |=> array_error_flag)
      else $error("error cleared");
   a_err_cause: assert property (|channel_error_vector |-> ##[0:1] array_error_flag)
      else $error("error missed");
   a_pop_busy: assert property (tx_user_fifo_pop |-> array_busy_flag)
      else $error("pop idle");
   a_cap_hold: assert property (!$stable(array_capacity_sectors) |-> $past(array_busy_flag))
      else $error("capacity moved");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rstr_pkg::*;
   // ====
   // Signals
   logic clk = 1'b0, srn = 1'b0, run = 1'b1, cs = 1'b0, sp = 1'b0, kp = 1'b0, ist = 1'b0;
   logic rdy, dn, kv;
   logic [2:0] cc = 3'h0, ecc;
   logic [47:0] ca = 48'h0, cn = 48'h0;
   logic [1:0] ereq, greq, ebz = 2'h0, elm = 2'h0, etp = 2'h0, erp = 2'h0, cst = 2'h0;
   logic [1:0][47:0] ead, eln, gad, gln, ecp = '0;
   logic [1:0][31:0] eer = '0;
   logic [1:0][127:0] etw, crw, erw = '0;
   logic [1:0][6:0] etl;
   logic [511:0] sub = '0, esw;
   logic [255:0] sw = '0, kw;
   logic [127:0] iwd = '0;
   logic [31:0] ird;
   logic [10:0] ira = 11'h0;
   logic [3:0] imk = 4'h0;
   int errors = 0, checked = 0, cyc = 0;
   rstr_if lnk ();
   rstr_user i_rstr_user (.clk(clk), .clk_en(run), .sync_reset_n(srn), .lnk(lnk),
      .cmd_start(cs), .cmd_code(cc), .cmd_sector(ca), .cmd_count(cn), .cmd_sub_words(sub),
      .cmd_ready(rdy), .cmd_done(dn), .src_push(sp), .src_word(sw), .src_room(),
      .snk_pop(kp), .snk_valid(kv), .snk_word(kw));
   rstr_array #(.FIFO_BYTES(1024)) i_rstr_array (.clk(clk), .clk_en(run),
      .sync_reset_n(srn), .lnk(lnk), .eng_cmd_req(ereq), .eng_cmd_code(ecc), .eng_addr(ead),
      .eng_len(eln), .eng_sub_words(esw), .eng_busy(ebz), .eng_err_type(eer),
      .eng_capacity(ecp), .eng_lba_mode(elm), .eng_tx_pop(etp), .eng_tx_word(etw),
      .eng_tx_level(etl), .eng_rx_push(erp), .eng_rx_word(erw), .eng_rx_level(),
      .iden_strobe(ist), .iden_mask(imk), .iden_index(9'h0), .iden_word(iwd),
      .iden_rd_addr(ira), .iden_rd_word(ird), .ctm_strobe(cst), .ctm_mask({2{imk}}),
      .ctm_index(10'h0), .ctm_word({2{iwd}}), .ctm_rd_word(crw));
   rstr_assertions i_chk (.clk(clk), .sync_reset_n(srn),
      .host_command_request(lnk.host_command_request), .array_busy_flag(lnk.array_busy_flag),
      .array_capacity_sectors(lnk.array_capacity_sectors),
      .array_error_flag(lnk.array_error_flag), .channel_error_vector(lnk.channel_error_vector),
      .rx_user_fifo_write_count(lnk.rx_user_fifo_write_count),
      .rx_user_fifo_push(lnk.rx_user_fifo_push),
      .tx_user_fifo_read_count(lnk.tx_user_fifo_read_count),
      .tx_user_fifo_pop(lnk.tx_user_fifo_pop));
   // ====
   // Clock, engines answering busy, timeout
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      ebz <= ereq;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         wrap_up;
      end
   end
   // ====
   // Tasks
   task chk(input logic [511:0] g, input logic [511:0] e);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task cmd(input logic [2:0] c, input logic [47:0] a, input logic [47:0] n);
      while (!rdy) @(posedge clk);
      cc <= c;
      ca <= a;
      cn <= n;
      cs <= 1'b1;
      greq = 2'h0;
      @(posedge clk) cs <= 1'b0;
      do
      begin
         @(negedge clk);
         if (ereq != 2'h0 && greq == 2'h0)
         begin
            greq = ereq;
            gad = ead;
            gln = eln;
         end
      end
      while (!dn);
      @(posedge clk);
   endtask
   task wrap_up;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ====
   // Tests
   logic [2:0] codes [4] = '{CMD_IDENTIFY, CMD_SHUTDOWN, CMD_SMART, CMD_FLUSH};
   initial
   begin
      repeat (6) @(posedge clk);
      srn <= 1'b1;
      @(negedge clk) chk(lnk.array_capacity_sectors, 0);
      chk(lnk.sector_size_indicator, 0);
      @(posedge clk) ecp <= {48'h300, 48'h1f2};
      elm <= 2'h2;
      sub <= {16{32'h5a00c3e1}};
      foreach (codes[k])
      begin
         cmd(codes[k], 48'h0, 48'h0);
         chk(greq, 2'h3);
      end
      chk(lnk.array_capacity_sectors, 48'h4f2);
      chk(lnk.sector_size_indicator, 1'b1);
      chk(esw, sub);
      $display("commands done");
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk) sp <= 1'b1;
         sw <= {8{32'h100 + i}};
      end
      @(posedge clk) sp <= 1'b0;
      cmd(CMD_WRITE, 48'h1, 48'h1);
      chk(greq, 2'h2);
      chk({gad[1], gln[1]}, {48'h0, 48'h1});
      chk(etl, {7'h20, 7'h0});
      @(posedge clk) etp <= 2'h2;
      @(posedge clk) etp <= 2'h0;
      @(negedge clk) chk(etw[1], {4{32'h100}});
      $display("write done");
      for (int j = 0; j < 32; j++)
      begin
         @(posedge clk) erp <= 2'h3;
         erw <= {{4{32'h200 + j}}, {4{32'h300 + j}}};
      end
      @(posedge clk) erp <= 2'h0;
      cmd(CMD_READ, 48'h2, 48'h2);
      chk({greq, gad, gln}, {2'h3, 48'h1, 48'h1, 48'h1, 48'h1});
      chk(ecc, CMD_READ);
      for (int j = 0; j < 32; j++)
      begin
         @(posedge clk) kp <= 1'b1;
         @(posedge clk) kp <= 1'b0;
         @(negedge clk) chk(kv, 1'b1);
         if (j == 0)
            chk(kw, {{4{32'h301}}, {4{32'h300}}});
         if (j == 16)
            chk(kw, {{4{32'h201}}, {4{32'h200}}});
      end
      $display("read done");
      @(posedge clk) ist <= 1'b1;
      cst <= 2'h1;
      imk <= 4'hf;
      @(posedge clk) imk <= 4'h2;
      iwd <= '1;
      @(posedge clk) ist <= 1'b0;
      cst <= 2'h0;
      ira <= 11'h1;
      @(posedge clk) ira <= 11'h0;
      @(negedge clk) chk(ird, 32'hffffffff);
      chk(crw, {2{64'h0, 32'hffffffff, 32'h0}});
      @(negedge clk) chk(ird, 32'h0);
      @(posedge clk) eer <= {32'h4, 32'h0};
      @(posedge clk) eer <= '0;
      @(negedge clk) chk(lnk.channel_error_vector, {32'h4, 32'h0});
      repeat (3) @(negedge clk);
      chk({lnk.array_error_flag, lnk.channel_error_vector}, {1'b1, 64'h0});
      $display("buffer and error done");
      wrap_up;
   end
endmodule
`default_nettype wire
